// File: verilog/rot_pkg.sv
// package for the byte rotate unit: opcodes, widths, carrier types, reset values
package rot_pkg;

    localparam int DATA_W = 8;
    localparam int TOP_BIT = 7;
    localparam int BOTTOM_BIT = 0;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic CARRY_RESET = 1'b0;
    localparam int RESULT_LATENCY = 1;

    // rotate instruction family
    typedef enum logic [2:0] {
        rotl_mem,
        rotl_to_acc,
        rotl_carry_mem,
        rotl_carry_to_acc,
        rotr_mem,
        rotr_to_acc,
        rotr_carry_mem,
        rotr_carry_to_acc
    } rot_op_type;

    // request from decode: operation plus memory operand
    typedef struct packed {
        rot_op_type op;
        logic [7:0] operand;
    } rot_req_type;

    // answer toward data memory and accumulator write ports
    typedef struct packed {
        logic memWrite;
        logic accWrite;
        logic carryWrite;
        logic [7:0] data;
    } rot_res_type;

endpackage

// File: verilog/rot_shift.sv
// combinational one-bit rotate of a byte with a chosen fill bit
`timescale 1ns/1ps
module rot_shift (
    // control
    input wire logic toRight,
    input wire logic fillBit,
    // data
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic outBit
);
    import rot_pkg::*;

    // shift one place and insert fill at the vacated end
    always_comb begin
        if (toRight) begin
            dataOut = {fillBit, dataIn[TOP_BIT:1]};
            outBit = dataIn[BOTTOM_BIT];
        end else begin
            dataOut = {dataIn[TOP_BIT-1:0], fillBit};
            outBit = dataIn[TOP_BIT];
        end
    end

endmodule

// File: verilog/byte_rotate_unit.sv
// byte rotate unit: executes the eight rotate instructions on a memory operand
`timescale 1ns/1ps
module byte_rotate_unit (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // request from decode
    input wire logic reqValid,
    input wire rot_pkg::rot_req_type req,
    // flag state
    input wire logic carryIn,
    // results
    output logic doneValid,
    output rot_pkg::rot_res_type res,
    output logic [7:0] accOut,
    output logic carryOut
);
    import rot_pkg::*;

    // timing of one rotate:
    // - taken at the edge where reqValid is high
    // - strobes, byte and carry show one edge later
    // - strobes and done pulse last one cycle
    // - byte and accumulator hold until the next qualifying request
    // - back to back requests are taken every cycle
    // - while idle the carry state follows the core flag
    // - a rotate through carry chains on the carry just produced

    // decoded operation
    logic toRight;
    logic throughCarry;
    logic toAcc;

    // rotate datapath
    logic wrapBit;
    logic fillBit;
    logic [7:0] rotated;
    logic outBit;

    // request qualifiers by destination
    logic takeMem;
    logic takeAcc;
    logic takeCarry;

    // registered answer and next values
    logic doneValid_r;
    logic memWrite_r;
    logic accWrite_r;
    logic carryWrite_r;
    logic [7:0] data_r;
    logic [7:0] data_nxt;
    logic [7:0] acc_r;
    logic [7:0] acc_nxt;
    logic carry_r;
    logic carry_nxt;

    // decode the opcode into direction, carry use and destination
    always_comb begin
        toRight = 1'b0;
        throughCarry = 1'b0;
        toAcc = 1'b0;
        unique case (req.op)
            rotl_mem: begin
            end
            rotl_to_acc: toAcc = 1'b1;
            rotl_carry_mem: throughCarry = 1'b1;
            rotl_carry_to_acc: begin
                throughCarry = 1'b1;
                toAcc = 1'b1;
            end
            rotr_mem: toRight = 1'b1;
            rotr_to_acc: begin
                toRight = 1'b1;
                toAcc = 1'b1;
            end
            rotr_carry_mem: begin
                toRight = 1'b1;
                throughCarry = 1'b1;
            end
            rotr_carry_to_acc: begin
                toRight = 1'b1;
                throughCarry = 1'b1;
                toAcc = 1'b1;
            end
        endcase
    end

    assign wrapBit = toRight ? req.operand[BOTTOM_BIT] : req.operand[TOP_BIT];

    always_comb begin
        if (throughCarry) begin
            fillBit = carry_r;
        end else begin
            fillBit = wrapBit;
        end
    end

    // one-place rotate with the chosen fill
    rot_shift shifter (
        .toRight(toRight),
        .fillBit(fillBit),
        .dataIn(req.operand),
        .dataOut(rotated),
        .outBit(outBit)
    );

    // qualify the request once per destination
    // no memory write for accumulator forms
    assign takeMem = reqValid && !toAcc;
    assign takeAcc = reqValid && toAcc;
    assign takeCarry = reqValid && throughCarry;

    always_comb begin
        carry_nxt = carryIn;
        if (takeCarry) begin
            carry_nxt = outBit;
        end
    end

    // carry state; a rotate through carry takes the place of the core flag
    always_ff @(posedge clk) begin
        if (!rstn) begin
            carry_r <= CARRY_RESET;
        end else begin
            carry_r <= carry_nxt;
        end
    end

    // one-cycle completion pulse per accepted rotate
    always_ff @(posedge clk) begin
        if (!rstn) begin
            doneValid_r <= 1'b0;
        end else begin
            doneValid_r <= reqValid;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            memWrite_r <= 1'b0;
        end else begin
            memWrite_r <= takeMem;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            accWrite_r <= 1'b0;
        end else begin
            accWrite_r <= takeAcc;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            carryWrite_r <= 1'b0;
        end else begin
            carryWrite_r <= takeCarry;
        end
    end

    // result byte holds until the next accepted rotate
    always_comb begin
        data_nxt = data_r;
        if (reqValid) begin
            data_nxt = rotated;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            data_r <= DATA_RESET;
        end else begin
            data_r <= data_nxt;
        end
    end

    // memory forms leave the accumulator alone
    always_comb begin
        acc_nxt = acc_r;
        if (takeAcc) begin
            acc_nxt = rotated;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            acc_r <= ACC_RESET;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    // drive the outputs from the flip-flops
    assign doneValid = doneValid_r;
    assign res = '{memWrite: memWrite_r, accWrite: accWrite_r, carryWrite: carryWrite_r,
        data: data_r};
    assign accOut = acc_r;
    assign carryOut = carry_r;

endmodule

// File: tb/rot_sva.sv
// assertions for the byte rotate unit
`timescale 1ns/1ps
module rot_sva (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // request
    input wire logic reqValid,
    input wire rot_pkg::rot_req_type req,
    input wire logic carryIn,
    // results
    input wire logic doneValid,
    input wire rot_pkg::rot_res_type res,
    input wire logic [7:0] accOut,
    input wire logic carryOut
);
    import rot_pkg::*;
    logic [2:0] o;
    logic [7:0] d;
    logic [8:0] e;
    // expected new carry and byte, fill from carry state
    assign o = req.op;
    assign d = req.operand;
    assign e = o[2] ? {d[0], o[1] ? carryOut : d[0], d[7:1]} : {d[7], d[6:0], o[1] ? carryOut : d[7]};
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_done; reqValid |=> doneValid; endproperty
    a_done: assert property (p_done) else $error("done missing");
    property p_idle;
        !reqValid |=> !doneValid && !res.memWrite && !res.accWrite && !res.carryWrite;
    endproperty
    a_idle: assert property (p_idle) else $error("stray strobe");
    property p_data; reqValid |=> res.data == $past(e[7:0]); endproperty
    a_data: assert property (p_data) else $error("bad byte");
    property p_mem; reqValid && !o[0] |=> res.memWrite && !res.accWrite; endproperty
    a_mem: assert property (p_mem) else $error("bad mem write");
    property p_acc; reqValid && o[0] |=> res.accWrite && !res.memWrite && accOut == $past(e[7:0]);
    endproperty
    a_acc: assert property (p_acc) else $error("bad acc");
    property p_keep; reqValid && !o[0] |=> $stable(accOut); endproperty
    a_keep: assert property (p_keep) else $error("acc changed");
    property p_cy; reqValid && o[1] |=> res.carryWrite && carryOut == $past(e[8]); endproperty
    a_cy: assert property (p_cy) else $error("bad carry");
    property p_nocy; reqValid && !o[1] |=> !res.carryWrite && carryOut == $past(carryIn); endproperty
    a_nocy: assert property (p_nocy) else $error("carry changed");
endmodule

// File: tb/rot_partner.sv
// data memory model taking write-backs from the rotate unit
`timescale 1ns/1ps
module rot_partner (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // write port
    input wire rot_pkg::rot_res_type res,
    // stored byte
    output logic [7:0] mem
);
    import rot_pkg::*;
    // store the byte on a memory write strobe
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mem <= 8'h00;
        end else if (res.memWrite) begin
            mem <= res.data;
        end
    end
endmodule

// File: tb/byte_rotate_unit_bench.sv
// testbench for the byte rotate unit
`timescale 1ns/1ps
module byte_rotate_unit_bench;
    import rot_pkg::*;
    logic clk = 0, rstn = 0, reqValid = 0, carryIn = 0, doneValid, carryOut;
    rot_req_type req = '0;
    rot_res_type res;
    logic [7:0] accOut, mem;
    int fail_count = 0, check_count = 0;
    // clock
    always #5 clk = ~clk;
    byte_rotate_unit i_byte_rotate_unit (.clk(clk), .rstn(rstn), .reqValid(reqValid), .req(req),
        .carryIn(carryIn), .doneValid(doneValid), .res(res), .accOut(accOut), .carryOut(carryOut));
    rot_partner i_rot_partner (.clk(clk), .rstn(rstn), .res(res), .mem(mem));
    task chk(input string nm, input logic [8:0] exp, input logic [8:0] seen);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // one request, then judge strobes, byte, acc, carry, memory
    task run(input logic [2:0] o, input logic [7:0] d, input logic c);
        logic [7:0] m, a, r;
        logic f;
        m = mem;
        a = accOut;
        f = o[1] ? c : (o[2] ? d[0] : d[7]);
        r = o[2] ? {f, d[7:1]} : {d[6:0], f};
        carryIn = c;
        @(posedge clk) #1;
        req = '{rot_op_type'(o), d};
        reqValid = 1;
        @(posedge clk) #1;
        reqValid = 0;
        chk("byte", {1'b0, r}, {1'b0, res.data});
        chk("strobes", {5'h0, 1'b1, ~o[0], o[0], o[1]},
            {5'h0, doneValid, res.memWrite, res.accWrite, res.carryWrite});
        chk("acc", {1'b0, o[0] ? r : a}, {1'b0, accOut});
        chk("carry", {8'h00, o[1] ? (o[2] ? d[0] : d[7]) : c}, {8'h00, carryOut});
        @(posedge clk) #1;
        chk("mem", {1'b0, o[0] ? m : r}, {1'b0, mem});
    endtask
    // every form with both carry values at edge bits
    task t_all;
        for (int i = 0; i < 16; i++) begin
            run(3'(i >> 1), i[0] ? 8'h7e : 8'h81, i[0]);
        end
        $display("t_all done");
    endtask
    // back to back through-carry forms chain the carry
    task t_b2b;
        carryIn = 0;
        @(posedge clk) #1;
        req = '{rotl_carry_mem, 8'h81};
        reqValid = 1;
        @(posedge clk) #1;
        chk("first", 9'h102, {carryOut, res.data});
        req = '{rotr_carry_to_acc, 8'h02};
        @(posedge clk) #1;
        reqValid = 0;
        chk("second", 9'h081, {carryOut, accOut});
        $display("t_b2b done");
    endtask
    task print_verdict;
        $display("checks %0d fails %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // hold reset for 16 cycles, then check reset values
    task t_power_up;
        repeat (16) @(posedge clk);
        #1 rstn = 1;
        chk("reset", 9'h000, {doneValid, accOut});
        chk("reset byte", {CARRY_RESET, DATA_RESET}, {carryOut, res.data});
        $display("t_power_up done");
    endtask
    // reset in mid-run clears results; carry mirror and requests resume after release
    task t_reset;
        carryIn = 1;
        @(posedge clk) #1;
        req = '{rotl_to_acc, 8'h81};
        reqValid = 1;
        @(posedge clk) #1;
        reqValid = 0;
        rstn = 0;
        chk("pre reset acc", {1'b0, 8'h03}, {1'b0, accOut});
        @(posedge clk) #1;
        chk("rst byte", {1'b0, DATA_RESET}, {doneValid, res.data});
        chk("rst acc", {CARRY_RESET, ACC_RESET}, {carryOut, accOut});
        chk("rst strobes", 9'h000, {6'h00, res.memWrite, res.accWrite, res.carryWrite});
        rstn = 1;
        @(posedge clk) #1;
        chk("rst mirror", {1'b1, ACC_RESET}, {carryOut, accOut});
        run(3'h6, 8'h81, 1'b1);
        $display("t_reset done");
    endtask
    // reset, then scenarios
    initial begin
        t_power_up;
        t_all;
        t_b2b;
        t_reset;
        print_verdict;
    end
endmodule
bind byte_rotate_unit rot_sva i_rot_sva (.clk(clk), .rstn(rstn), .reqValid(reqValid), .req(req),
    .carryIn(carryIn), .doneValid(doneValid), .res(res), .accOut(accOut), .carryOut(carryOut));
